// ==== dpio_pkg.sv ====
// Behaviour
// - direction bit one puts the pin driver in high impedance, pin is input
// - direction bit zero drives the pin from its output latch
// - latch register reads return the latched value, not the pins
// - an enabled peripheral may force a first-port pin to output or input
// - forced direction never lands in the stored direction register
// - first-port bits 0..2 carry timer oscillator, timer clock and capture/compare/pwm
// - first-port bits 3..5 carry serial clock, serial data in/io and data out
// - first-port bits 6 and 7 carry usart transmit/clock and receive/data
// - second port is general I/O only once the bus-disable bit is set
// - in bus mode second port carries the low bus byte
// - 16-bit mode multiplexes address/data; 8-bit large-device mode carries address only
// - after power-on the second port belongs to the system bus
// - reset_i loads all ones into the direction registers; power_on_reset_i alone leaves them unchanged
// - port register read returns pins, write stores into the output latch
package dpio_pkg;
   // ************************************************************
   // register map (word offsets in bytes)
   // ************************************************************
   localparam logic [4:0] DPIO_ADDR_PINS_C = 5'h00;
   localparam logic [4:0] DPIO_ADDR_LATCH_C = 5'h04;
   localparam logic [4:0] DPIO_ADDR_DIR_C = 5'h08;
   localparam logic [4:0] DPIO_ADDR_PINS_D = 5'h0C;
   localparam logic [4:0] DPIO_ADDR_LATCH_D = 5'h10;
   localparam logic [4:0] DPIO_ADDR_DIR_D = 5'h14;
   localparam logic [4:0] DPIO_ADDR_MEMCTL = 5'h18;
   // ************************************************************
   // field layout and reset values
   // ************************************************************
   localparam int DPIO_BUS_OFF_BIT = 7;
   localparam logic [7:0] DPIO_DIR_RESET = 8'hFF;
   localparam logic [7:0] DPIO_LATCH_RESET = 8'h00;
   localparam logic [7:0] DPIO_MEMCTL_RESET = 8'h00;
   localparam logic [7:0] DPIO_MEMCTL_MASK = 8'hF3;
   localparam logic [31:0] DPIO_UNMAPPED_DATA = 32'h0000_0000;
   typedef enum logic {
      DPIO_IDLE,
      DPIO_ANSWER
   } dpio_bus_state_type;
endpackage : dpio_pkg

// ==== dpio_pin_cell.sv ====
module dpio_pin_cell
   import dpio_pkg::*;
(
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_i,
   // control
   input wire logic dir_in_i,
   input wire logic latch_i,
   input wire logic ovr_en_i,
   input wire logic ovr_in_i,
   input wire logic ovr_data_i,
   // pin
   output logic pin_o,
   output logic pin_oe_o
);
   // ************************************************************
   // registered pin driver
   // ************************************************************
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         pin_oe_o <= 1'b0;
         pin_o <= 1'b0;
      end else if (ovr_en_i) begin
         pin_oe_o <= !ovr_in_i;
         pin_o <= ovr_data_i;
      end else begin
         pin_oe_o <= !dir_in_i;
         pin_o <= latch_i;
      end
   end

   a_pin_drive: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      !ovr_en_i |=> pin_oe_o == !$past(dir_in_i) && (!pin_oe_o || pin_o == $past(latch_i)))
      else $error("pin drive does not follow direction and latch");
   a_pin_override: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      ovr_en_i |=> pin_oe_o == !$past(ovr_in_i))
      else $error("peripheral override not applied");
endmodule : dpio_pin_cell

// ==== dpio_top.sv ====
// Design decisions made here: the placing of the registers and the Avalon-MM slave port.
module dpio_top
   import dpio_pkg::*;
(
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_i,
   input wire logic power_on_reset_i,
   // avalon-mm slave
   input wire logic [4:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // first port pins
   input wire logic [7:0] port_c_i,
   output logic [7:0] port_c_o,
   output logic [7:0] port_c_oe_o,
   // first port peripheral overrides, per bit
   input wire logic [7:0] periph_en_i,
   input wire logic [7:0] periph_in_i,
   input wire logic [7:0] periph_data_i,
   output logic [7:0] periph_pin_o,
   // second port pins
   input wire logic [7:0] port_d_i,
   output logic [7:0] port_d_o,
   output logic [7:0] port_d_oe_o,
   // system bus side of second port
   input wire logic [7:0] bus_low_byte_i,
   input wire logic bus_low_byte_oe_i,
   output logic [7:0] bus_low_byte_o,
   output logic external_bus_off_o
);
   import dpio_pkg::*;

   logic [7:0] output_latch_c_q;
   logic [7:0] direction_c_q;
   logic [7:0] output_latch_d_q;
   logic [7:0] direction_d_q;
   logic [7:0] memory_bus_control_q;
   dpio_bus_state_type state_q;
   logic [31:0] rdata_d;
   logic access;
   logic wr_en;
   logic bus_owns;
   logic [7:0] d_dir_eff;
   logic [7:0] d_lat_eff;
   logic [7:0] d_ovr_in;

   // ************************************************************
   // avalon slave: one wait cycle, answer on the second edge
   // ************************************************************
   assign access = avs_read_i || avs_write_i;
   assign wr_en = avs_write_i && (state_q == DPIO_IDLE) && avs_byteenable_i[0];

   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         state_q <= DPIO_IDLE;
      end else begin
         unique case (state_q)
            DPIO_IDLE: begin
               if (access) begin
                  state_q <= DPIO_ANSWER;
               end
            end
            DPIO_ANSWER: begin
               state_q <= DPIO_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         avs_waitrequest_o <= 1'b1;
      end else begin
         avs_waitrequest_o <= !(access && state_q == DPIO_IDLE);
      end
   end

   always_comb begin
      rdata_d = DPIO_UNMAPPED_DATA;
      unique case (avs_address_i)
         DPIO_ADDR_PINS_C: rdata_d[7:0] = port_c_i;
         DPIO_ADDR_LATCH_C: rdata_d[7:0] = output_latch_c_q;
         DPIO_ADDR_DIR_C: rdata_d[7:0] = direction_c_q;
         DPIO_ADDR_PINS_D: rdata_d[7:0] = port_d_i;
         DPIO_ADDR_LATCH_D: rdata_d[7:0] = output_latch_d_q;
         DPIO_ADDR_DIR_D: rdata_d[7:0] = direction_d_q;
         DPIO_ADDR_MEMCTL: rdata_d[7:0] = memory_bus_control_q;
         default: rdata_d = DPIO_UNMAPPED_DATA;
      endcase
   end

   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         avs_readdata_o <= DPIO_UNMAPPED_DATA;
      end else if (avs_read_i && state_q == DPIO_IDLE) begin
         avs_readdata_o <= rdata_d;
      end
   end

   // ************************************************************
   // registers
   // ************************************************************
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         output_latch_c_q <= DPIO_LATCH_RESET;
         output_latch_d_q <= DPIO_LATCH_RESET;
      end else if (wr_en) begin
         if (avs_address_i == DPIO_ADDR_PINS_C || avs_address_i == DPIO_ADDR_LATCH_C) begin
            output_latch_c_q <= avs_writedata_i[7:0];
         end
         if (avs_address_i == DPIO_ADDR_PINS_D || avs_address_i == DPIO_ADDR_LATCH_D) begin
            output_latch_d_q <= avs_writedata_i[7:0];
         end
      end
   end

   // direction only ever takes software writes, never peripheral forcing
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         direction_c_q <= DPIO_DIR_RESET;
         direction_d_q <= DPIO_DIR_RESET;
      end else if (wr_en) begin
         if (avs_address_i == DPIO_ADDR_DIR_C) begin
            direction_c_q <= avs_writedata_i[7:0];
         end
         if (avs_address_i == DPIO_ADDR_DIR_D) begin
            direction_d_q <= avs_writedata_i[7:0];
         end
      end
   end

   // memory control survives non power-on resets; power-on returns pins to the bus
   always_ff @(posedge ref_clk_i or posedge power_on_reset_i) begin
      if (power_on_reset_i) begin
         memory_bus_control_q <= DPIO_MEMCTL_RESET;
      end else if (wr_en && avs_address_i == DPIO_ADDR_MEMCTL) begin
         memory_bus_control_q <= avs_writedata_i[7:0] & DPIO_MEMCTL_MASK;
      end
   end

   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         external_bus_off_o <= 1'b0;
      end else begin
         external_bus_off_o <= memory_bus_control_q[DPIO_BUS_OFF_BIT];
      end
   end

   // ************************************************************
   // first port: peripheral overrides per bit
   // ************************************************************
   // bit map: 0 timer osc out/ext clock, 1 timer osc in, 2 ccp, 3 serial clock,
   // 4 serial data in/io, 5 serial data out, 6 usart tx/clock, 7 usart rx/data
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_c
         dpio_pin_cell u_cell (
            .ref_clk_i(ref_clk_i),
            .reset_i(reset_i),
            .dir_in_i(direction_c_q[gi]),
            .latch_i(output_latch_c_q[gi]),
            .ovr_en_i(periph_en_i[gi]),
            .ovr_in_i(periph_in_i[gi]),
            .ovr_data_i(periph_data_i[gi]),
            .pin_o(port_c_o[gi]),
            .pin_oe_o(port_c_oe_o[gi])
         );
      end
   endgenerate

   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         periph_pin_o <= 8'h00;
      end else begin
         periph_pin_o <= port_c_i;
      end
   end

   // ************************************************************
   // second port: bus or general I/O
   // ************************************************************
   assign bus_owns = !memory_bus_control_q[DPIO_BUS_OFF_BIT];
   // bus drives low address/data byte; address-only 8-bit mode is the bus oe held high
   assign d_ovr_in = {8{!bus_low_byte_oe_i}};
   assign d_dir_eff = direction_d_q;
   assign d_lat_eff = output_latch_d_q;

   generate
      for (gi = 0; gi < 8; gi++) begin : g_d
         dpio_pin_cell u_cell (
            .ref_clk_i(ref_clk_i),
            .reset_i(reset_i),
            .dir_in_i(d_dir_eff[gi]),
            .latch_i(d_lat_eff[gi]),
            .ovr_en_i(bus_owns),
            .ovr_in_i(d_ovr_in[gi]),
            .ovr_data_i(bus_low_byte_i[gi]),
            .pin_o(port_d_o[gi]),
            .pin_oe_o(port_d_oe_o[gi])
         );
      end
   endgenerate

   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         bus_low_byte_o <= 8'h00;
      end else begin
         bus_low_byte_o <= port_d_i;
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   a_bus_answer: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (access && state_q == DPIO_IDLE) |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
      else $error("bus answer not one cycle after request");
   a_latch_readback: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (avs_read_i && state_q == DPIO_IDLE && avs_address_i == DPIO_ADDR_LATCH_C)
      |=> avs_readdata_o[7:0] == $past(output_latch_c_q))
      else $error("latch read does not return latch");
   a_dir_sticky: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      !(wr_en && avs_address_i == DPIO_ADDR_DIR_C) |=> $stable(direction_c_q))
      else $error("direction changed without a write");
   a_bus_owns_d: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (bus_owns && $past(bus_owns) && !$past(reset_i))
      |-> port_d_oe_o == {8{$past(bus_low_byte_oe_i)}})
      else $error("second port not under bus control");
   a_io_mode_d: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (!bus_owns && $past(!bus_owns) && !$past(reset_i))
      |-> port_d_oe_o == ~$past(direction_d_q))
      else $error("second port not following direction");
   a_reset_dirs: assert property (@(posedge ref_clk_i)
      $fell(reset_i) |-> direction_c_q == DPIO_DIR_RESET && direction_d_q == DPIO_DIR_RESET)
      else $error("direction not all ones after reset");
endmodule : dpio_top

// ==== dpio_board.sv ====
module dpio_board (
   // device side of the pins
   input wire logic [7:0] dev_c_i,
   input wire logic [7:0] dev_c_oe_i,
   input wire logic [7:0] dev_d_i,
   input wire logic [7:0] dev_d_oe_i,
   // board drivers
   input wire logic [7:0] ext_c_i,
   input wire logic [7:0] ext_d_i,
   // resolved pin levels
   output logic [7:0] pin_c_o,
   output logic [7:0] pin_d_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // undriven bits follow the board, so a stale device level cannot pass for a pin
   assign pin_c_o = (dev_c_i & dev_c_oe_i) | (ext_c_i & ~dev_c_oe_i);
   assign pin_d_o = (dev_d_i & dev_d_oe_i) | (ext_d_i & ~dev_d_oe_i);
endmodule : dpio_board

// ==== dpio_tb.sv ====
module tb
   import dpio_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, rst = 1'b1, por = 1'b1, rd = 1'b0, wr = 1'b0, boe = 1'b1, wreq, boff;
   logic [4:0] adr = 5'h00;
   logic [31:0] wdat = 32'h0, rdat;
   logic [7:0] pc_i, pc_o, pc_oe, pd_i, pd_o, pd_oe, ppin, bo, q;
   logic [7:0] pen = 8'h00, pin = 8'h00, pdat = 8'h00, bd = 8'h00;
   logic [7:0] ext_c = 8'h3C, ext_d = 8'h3C;
   logic [3:0] be = 4'hF;
   int miscompares = 0, check_count = 0;
   always #20 clk = ~clk;
   dpio_top uut (.ref_clk_i(clk), .reset_i(rst), .power_on_reset_i(por),
      .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
      .avs_byteenable_i(be), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
      .port_c_i(pc_i), .port_c_o(pc_o), .port_c_oe_o(pc_oe), .periph_en_i(pen),
      .periph_in_i(pin), .periph_data_i(pdat), .periph_pin_o(ppin), .port_d_i(pd_i),
      .port_d_o(pd_o), .port_d_oe_o(pd_oe), .bus_low_byte_i(bd), .bus_low_byte_oe_i(boe),
      .bus_low_byte_o(bo), .external_bus_off_o(boff));
   dpio_board board (.dev_c_i(pc_o), .dev_c_oe_i(pc_oe), .dev_d_i(pd_o), .dev_d_oe_i(pd_oe),
      .ext_c_i(ext_c), .ext_d_i(ext_d), .pin_c_o(pc_i), .pin_d_o(pd_i));
   // ************************************************************
   // tasks
   // ************************************************************
   task wrap_up;
      if (miscompares == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : wrap_up
   task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // request held until waitrequest is sampled low
   task acc(input logic w, input logic [4:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk);
      adr <= a;
      rd <= ~w;
      wr <= w;
      wdat <= {24'h0, d};
      do begin
         @(posedge clk);
         n++;
      end while (wreq !== 1'b0 && n < 50);
      if (n >= 50) miscompares++;
      q = rdat[7:0];
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : acc
   task rchk(input string nm, input logic [4:0] a, input logic [7:0] e);
      acc(1'b0, a, 8'h00);
      chk(nm, e, q);
   endtask : rchk
   task settle;
      repeat (3) @(posedge clk);
      #1;
   endtask : settle
   // ************************************************************
   // tests
   // ************************************************************
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      por <= 1'b0;
      settle;
      chk("oe_c", 8'h00, pc_oe);
      chk("bus_off", 8'h00, {7'h0, boff});
      rchk("dir_c", DPIO_ADDR_DIR_C, 8'hFF);
      rchk("dir_d", DPIO_ADDR_DIR_D, 8'hFF);
      rchk("memctl", DPIO_ADDR_MEMCTL, 8'h00);
      acc(1'b1, DPIO_ADDR_LATCH_C, 8'hA5);
      acc(1'b1, DPIO_ADDR_DIR_C, 8'h0F);
      settle;
      chk("oe_c", 8'hF0, pc_oe);
      chk("out_c", 8'hA0, pc_o & pc_oe);
      rchk("latch_c", DPIO_ADDR_LATCH_C, 8'hA5);
      rchk("pins_c", DPIO_ADDR_PINS_C, 8'hAC);
      chk("periph_pin", 8'hAC, ppin);
      acc(1'b1, DPIO_ADDR_PINS_C, 8'h5A);
      rchk("latch_c", DPIO_ADDR_LATCH_C, 8'h5A);
      // a write without the low byte lane must leave the latch alone
      be <= 4'hE;
      acc(1'b1, DPIO_ADDR_LATCH_C, 8'h00);
      be <= 4'hF;
      rchk("latch_c", DPIO_ADDR_LATCH_C, 8'h5A);
      // bit 1 forced out against its direction bit, bit 7 forced in
      pen <= 8'h82;
      pin <= 8'h80;
      pdat <= 8'h02;
      settle;
      chk("oe_c", 8'h72, pc_oe);
      chk("out_c", 8'h02, pc_o & 8'h02);
      rchk("dir_c", DPIO_ADDR_DIR_C, 8'h0F);
      acc(1'b1, DPIO_ADDR_DIR_C, 8'hFF);
      for (int i = 0; i < 8; i++) begin
         pen <= 8'h01 << i;
         pin <= 8'h00;
         pdat <= 8'h01 << i;
         settle;
         chk("oe_c", 8'h01 << i, pc_oe);
         chk("out_c", 8'h01 << i, pc_o & pc_oe);
      end
      pen <= 8'h00;
      bd <= 8'h96;
      acc(1'b1, DPIO_ADDR_DIR_D, 8'h00);
      acc(1'b1, DPIO_ADDR_LATCH_D, 8'h5A);
      settle;
      chk("oe_d", 8'hFF, pd_oe);
      chk("out_d", 8'h96, pd_o);
      boe <= 1'b0;
      settle;
      chk("oe_d", 8'h00, pd_oe);
      chk("bus_in", 8'h3C, bo);
      acc(1'b1, DPIO_ADDR_MEMCTL, 8'hFF);
      settle;
      chk("bus_off", 8'h01, {7'h0, boff});
      rchk("memctl", DPIO_ADDR_MEMCTL, 8'hF3);
      chk("oe_d", 8'hFF, pd_oe);
      chk("out_d", 8'h5A, pd_o);
      rchk("pins_d", DPIO_ADDR_PINS_D, 8'h5A);
      // a plain reset must not hand the second port back to the bus
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      settle;
      rchk("dir_c", DPIO_ADDR_DIR_C, 8'hFF);
      rchk("memctl", DPIO_ADDR_MEMCTL, 8'hF3);
      chk("oe_d", 8'h00, pd_oe);
      rchk("unmapped", 5'h1C, 8'h00);
      wrap_up;
   end
   initial begin
      repeat (3000) @(posedge clk);
      miscompares++;
      wrap_up;
   end
endmodule : tb
